//--- mpst_pkg.sv
`default_nettype none
// -----------------------------------------------------------------------------
// Shared constants of the PHY status tracker.
// -----------------------------------------------------------------------------
package mpst_pkg;

  // Register byte offsets.
  localparam logic [7:0] MPST_CONTROL_OFS = 8'h00;
  localparam logic [7:0] MPST_ACK_OFS = 8'h04;
  localparam logic [7:0] MPST_LINK_OFS = 8'h08;
  localparam logic [7:0] MPST_RAW_OFS = 8'h0c;
  localparam logic [7:0] MPST_MASKED_OFS = 8'h10;
  localparam logic [7:0] MPST_SEL_FIRST_OFS = 8'h14;
  localparam logic [7:0] MPST_SEL_SECOND_OFS = 8'h18;
  localparam logic [7:0] MPST_INT_STATUS_OFS = 8'h1c;
  localparam logic [7:0] MPST_INT_CLEAR_OFS = 8'h20;
  localparam logic [7:0] MPST_INT_ENABLE_OFS = 8'h24;

  // Field positions.
  localparam int MPST_FAULT_EN_BIT = 18;
  localparam int MPST_FAULT_BIT = 19;
  localparam int MPST_SEL_EN_BIT = 7;
  localparam int MPST_INT_FAULT_BIT = 2;

  // Reset values.
  localparam logic [31:0] MPST_FLAGS_RST = 32'h0000_0000;
  localparam logic [1:0] MPST_EVENTS_RST = 2'h0;
  localparam logic [4:0] MPST_SEL_ADDR_RST = 5'h00;
  localparam logic [2:0] MPST_INT_EN_RST = 3'h0;

  // AXI4-Lite response codes.
  localparam logic [1:0] MPST_RESP_OKAY = 2'h0;
  localparam logic [1:0] MPST_RESP_SLVERR = 2'h2;

endpackage : mpst_pkg
`default_nettype wire

//--- mpst_sync.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------------------
// Two flip-flop synchroniser for pin levels.
// -----------------------------------------------------------------------------
module mpst_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i, // Block clock.
  input wire logic reset_i, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] async_i, // Levels from outside the clock domain.
  output logic [WIDTH-1:0] sync_o // Levels after two flip-flops.
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } mpst_sync_s;

  mpst_sync_s st;
  mpst_sync_s next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st.first = async_i;
    next_st.second = st.first;
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.second;

endmodule // mpst_sync
`default_nettype wire

//--- mpst_fault_mon.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------------------
// Data pin read-back monitor.
// -----------------------------------------------------------------------------
module mpst_fault_mon (
  input wire logic clk_i, // Block clock.
  input wire logic reset_i, // Synchronous reset, active high.
  input wire logic enable_i, // Fault detection enabled.
  input wire logic mdclk_sync_i, // Synchronised management clock.
  input wire logic mdio_sync_i, // Synchronised data pin level.
  input wire logic drive_en_i, // Frame engine drives the data pin.
  input wire logic drive_value_i, // Level the frame engine drives.
  output logic fault_event_o // One-cycle pulse on a read-back mismatch.
);

  typedef struct packed {
    logic mdclk_prev;
    logic fault_event;
  } mpst_fault_s;

  mpst_fault_s st;
  mpst_fault_s next_st;

  // Compare pin and driven level at each rising management clock edge.
  always_comb begin
    next_st.mdclk_prev = mdclk_sync_i;
    next_st.fault_event = enable_i && drive_en_i && mdclk_sync_i && !st.mdclk_prev
                          && (mdio_sync_i != drive_value_i);
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fault_event_o = st.fault_event;

endmodule // mpst_fault_mon
`default_nettype wire

//--- mpst_tracker.sv
//Contract
// - Keep one acknowledge flag per PHY address in a 32-bit word.
// - A PHY access without acknowledge clears that address's acknowledge flag.
// - Every access, user or polling, updates the acknowledge flag of its address.
// - Acknowledge flags reset to zero; writing one clears, writing zero keeps.
// - Link flags change only on reads of a PHY's generic status register.
// - Link flag sets when the PHY acknowledges the status read and has link.
// - Link flag clears on no link or on a missing acknowledge.
// - The 32 link flags are read-only, reset to zero, writes ignored.
// - Two raw link-change bits 1-0 set when the selected PHY's link flag changes.
// - Raw bit 0 follows the first select entry, bit 1 the second.
// - Raw bits reset to zero; writing one clears, writing zero does nothing.
// - A masked view of the two events sits in bits 1-0, resetting to zero.
// - Masked bit is raw and enabled; writing one to it clears the event.
// - With detection enabled, a pin read-back mismatch sets a sticky fault and resets.
`timescale 1ns/10ps
`default_nettype none
module mpst_tracker
  import mpst_pkg::*;
(
  input wire logic clk_i, // Block clock, 40 MHz.
  input wire logic reset_i, // Synchronous reset, active high.
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  // Management bus pins and frame engine.
  input wire logic mdclk_i, // Management clock pin level.
  input wire logic mdio_data_i, // Data pin read-back level.
  input wire logic mdio_drive_en_i, // Frame engine drives the data pin.
  input wire logic mdio_drive_value_i, // Level the frame engine drives.
  input wire logic access_done_i, // One-cycle pulse: a PHY access ended.
  input wire logic [4:0] access_phy_addr_i, // PHY address of that access.
  input wire logic access_ack_i, // The PHY acknowledged the access.
  input wire logic access_status_read_i, // The access read the generic status register.
  input wire logic access_link_up_i, // Link bit of the status read data.
  output logic fault_reset_o, // One-cycle pulse resetting the frame engine.
  output logic link_change_irq_o, // Link-change interrupt level.
  output logic irq_o // Combined enabled interrupt level.
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------

  typedef struct packed {
    logic aw_ready;
    logic w_ready;
    logic aw_held;
    logic w_held;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_ready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] phy_ack_flags;
    logic [31:0] phy_linkup_flags;
    logic [1:0] link_change_raw_events;
    logic [1:0][4:0] sel_addr;
    logic [1:0] link_change_event_enable;
    logic pin_fault_detect_enable;
    logic fault;
    logic fault_reset;
    logic [2:0] int_enable;
    logic link_irq;
    logic irq;
  } mpst_main_s;

  mpst_main_s st;
  mpst_main_s next_st;

  logic [1:0] pins_sync;
  logic fault_event;
  logic wr_fire;
  logic [31:0] wr_mask;
  logic [31:0] wr_bits;
  logic [31:0] ack_clr;
  logic [1:0] raw_clr;
  logic fault_clr;
  logic new_link;
  logic [2:0] int_flags;

  // ---------------------------------------------------------------------------
  // Pin synchronisation and fault monitor
  // ---------------------------------------------------------------------------

  // The management clock and data pin come from outside the clock domain.
  mpst_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({mdclk_i, mdio_data_i}),
    .sync_o(pins_sync)
  );

  // Watches the data pin at each rising management clock edge.
  mpst_fault_mon u_fault_mon (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(st.pin_fault_detect_enable),
    .mdclk_sync_i(pins_sync[1]),
    .mdio_sync_i(pins_sync[0]),
    .drive_en_i(mdio_drive_en_i),
    .drive_value_i(mdio_drive_value_i),
    .fault_event_o(fault_event)
  );

  // ---------------------------------------------------------------------------
  // Register read view
  // ---------------------------------------------------------------------------

  // Returns the word seen by software at a register offset.
  function automatic logic [31:0] read_word(input mpst_main_s s, input logic [7:0] addr);
    logic [31:0] w;
    w = '0;
    unique case (addr)
      MPST_CONTROL_OFS: begin
        w[MPST_FAULT_EN_BIT] = s.pin_fault_detect_enable;
        w[MPST_FAULT_BIT] = s.fault;
      end
      MPST_ACK_OFS: w = s.phy_ack_flags;
      MPST_LINK_OFS: w = s.phy_linkup_flags;
      MPST_RAW_OFS: w[1:0] = s.link_change_raw_events;
      MPST_MASKED_OFS: w[1:0] = s.link_change_raw_events & s.link_change_event_enable;
      MPST_SEL_FIRST_OFS: begin
        w[4:0] = s.sel_addr[0];
        w[MPST_SEL_EN_BIT] = s.link_change_event_enable[0];
      end
      MPST_SEL_SECOND_OFS: begin
        w[4:0] = s.sel_addr[1];
        w[MPST_SEL_EN_BIT] = s.link_change_event_enable[1];
      end
      MPST_INT_STATUS_OFS: w[2:0] = {s.fault, s.link_change_raw_events};
      MPST_INT_ENABLE_OFS: w[2:0] = s.int_enable;
      default: w = '0;
    endcase
    return w;
  endfunction

  // Tells whether an offset holds a register.
  function automatic logic is_mapped(input logic [7:0] addr);
    logic m;
    m = 1'b0;
    unique case (addr)
      MPST_CONTROL_OFS, MPST_ACK_OFS, MPST_LINK_OFS, MPST_RAW_OFS, MPST_MASKED_OFS,
      MPST_SEL_FIRST_OFS, MPST_SEL_SECOND_OFS, MPST_INT_STATUS_OFS,
      MPST_INT_CLEAR_OFS, MPST_INT_ENABLE_OFS: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------

  // Bus handshakes, software writes, hardware updates and interrupts.
  always_comb begin
    next_st = st;
    new_link = 1'b0;
    int_flags = '0;

    // Address and data are taken independently and held until the write.
    if (s_axi_awvalid && st.aw_ready) begin
      next_st.aw_ready = 1'b0;
      next_st.aw_held = 1'b1;
      next_st.wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.w_ready) begin
      next_st.w_ready = 1'b0;
      next_st.w_held = 1'b1;
      next_st.wr_data = s_axi_wdata;
      next_st.wr_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.aw_ready = 1'b1;
      next_st.w_ready = 1'b1;
    end

    // The write takes effect once both halves are held.
    wr_fire = st.aw_held && st.w_held && !st.bvalid;
    wr_mask = {{8{st.wr_strb[3]}}, {8{st.wr_strb[2]}}, {8{st.wr_strb[1]}}, {8{st.wr_strb[0]}}};
    wr_bits = st.wr_data & wr_mask;
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.wr_addr) ? MPST_RESP_OKAY : MPST_RESP_SLVERR;
    end

    // One bits written to the clearable registers form the clear masks.
    ack_clr = (wr_fire && st.wr_addr == MPST_ACK_OFS) ? wr_bits : '0;
    raw_clr = '0;
    fault_clr = 1'b0;
    if (wr_fire) begin
      unique case (st.wr_addr)
        MPST_RAW_OFS: raw_clr = wr_bits[1:0];
        MPST_MASKED_OFS: raw_clr = wr_bits[1:0];
        MPST_INT_CLEAR_OFS: begin
          raw_clr = wr_bits[1:0];
          fault_clr = wr_bits[MPST_INT_FAULT_BIT];
        end
        MPST_CONTROL_OFS: begin
          fault_clr = wr_bits[MPST_FAULT_BIT];
          if (st.wr_strb[2]) begin
            next_st.pin_fault_detect_enable = st.wr_data[MPST_FAULT_EN_BIT];
          end
        end
        MPST_SEL_FIRST_OFS: begin
          if (st.wr_strb[0]) begin
            next_st.sel_addr[0] = st.wr_data[4:0];
            next_st.link_change_event_enable[0] = st.wr_data[MPST_SEL_EN_BIT];
          end
        end
        MPST_SEL_SECOND_OFS: begin
          if (st.wr_strb[0]) begin
            next_st.sel_addr[1] = st.wr_data[4:0];
            next_st.link_change_event_enable[1] = st.wr_data[MPST_SEL_EN_BIT];
          end
        end
        MPST_INT_ENABLE_OFS: begin
          if (st.wr_strb[0]) begin
            next_st.int_enable = st.wr_data[2:0];
          end
        end
        default: begin
          // Link flags and unmapped offsets ignore writes.
        end
      endcase
    end

    // Software clears first, so a hardware event in the same cycle wins.
    next_st.phy_ack_flags = st.phy_ack_flags & ~ack_clr;
    next_st.link_change_raw_events = st.link_change_raw_events & ~raw_clr;
    next_st.fault = st.fault & ~fault_clr;

    // Each finished access records whether its PHY acknowledged.
    if (access_done_i) begin
      next_st.phy_ack_flags[access_phy_addr_i] = access_ack_i;
    end

    // Only a generic status read refreshes the link flag of its address.
    if (access_done_i && access_status_read_i) begin
      new_link = access_ack_i && access_link_up_i;
      // Each select entry compares against the flag as it stood before this read,
      // so both entries see the change when they name the same PHY.
      for (int k = 0; k < 2; k++) begin
        if (st.sel_addr[k] == access_phy_addr_i
            && new_link != st.phy_linkup_flags[access_phy_addr_i]) begin
          next_st.link_change_raw_events[k] = 1'b1;
        end
      end
      next_st.phy_linkup_flags[access_phy_addr_i] = new_link;
    end

    // A read-back mismatch is sticky and restarts the frame engine.
    next_st.fault_reset = fault_event;
    if (fault_event) begin
      next_st.fault = 1'b1;
    end

    // Interrupt outputs follow the updated flags.
    next_st.link_irq = |(next_st.link_change_raw_events & next_st.link_change_event_enable);
    int_flags = {next_st.fault, next_st.link_change_raw_events};
    next_st.irq = |(int_flags & next_st.int_enable);

    // A read is answered in the cycle after the address is taken.
    if (s_axi_arvalid && st.ar_ready) begin
      next_st.ar_ready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = read_word(st, s_axi_araddr);
      next_st.rresp = is_mapped(s_axi_araddr) ? MPST_RESP_OKAY : MPST_RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.ar_ready = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------

  // All flags and bus state start cleared; ready signals start high.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
      st.aw_ready <= 1'b1;
      st.w_ready <= 1'b1;
      st.ar_ready <= 1'b1;
      st.phy_ack_flags <= MPST_FLAGS_RST;
      st.phy_linkup_flags <= MPST_FLAGS_RST;
      st.link_change_raw_events <= MPST_EVENTS_RST;
      st.sel_addr <= {MPST_SEL_ADDR_RST, MPST_SEL_ADDR_RST};
      st.int_enable <= MPST_INT_EN_RST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------

  // Every output is a field of the state register.
  assign s_axi_awready = st.aw_ready;
  assign s_axi_wready = st.w_ready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.ar_ready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign fault_reset_o = st.fault_reset;
  assign link_change_irq_o = st.link_irq;
  assign irq_o = st.irq;

endmodule // mpst_tracker
`default_nettype wire

//--- mpst_tracker_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Port checks of the PHY status tracker.
// ------------------------------------------
module mpst_tracker_checker (
  input wire logic clk_i, // Clock.
  input wire logic reset_i, // Reset.
  input wire logic s_axi_awvalid, // Aw valid.
  input wire logic s_axi_awready, // Aw ready.
  input wire logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic [1:0] s_axi_bresp, // B code.
  input wire logic s_axi_bvalid, // B valid.
  input wire logic s_axi_bready, // B ready.
  input wire logic s_axi_arvalid, // Ar valid.
  input wire logic s_axi_arready, // Ar ready.
  input wire logic [31:0] s_axi_rdata, // R data.
  input wire logic s_axi_rvalid, // R valid.
  input wire logic s_axi_rready, // R ready.
  input wire logic access_done_i, // Access ended.
  input wire logic access_status_read_i, // Status read.
  input wire logic fault_reset_o, // Fault pulse.
  input wire logic link_change_irq_o // Link interrupt.
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Bus answers come on time and stand until taken.
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  // Interrupt and fault outputs follow their causes.
  property p_rst; $past(reset_i) |-> !link_change_irq_o && !fault_reset_o; endproperty
  a_rst: assert property (p_rst) else $error("output set out of reset");
  property p_flt; fault_reset_o |=> !fault_reset_o; endproperty
  a_flt: assert property (p_flt) else $error("fault pulse too long");
  property p_rise;
    $rose(link_change_irq_o) |-> $past(access_done_i && access_status_read_i) || $rose(s_axi_bvalid);
  endproperty
  a_rise: assert property (p_rise) else $error("link interrupt without cause");
  property p_fall; $fell(link_change_irq_o) |-> $rose(s_axi_bvalid); endproperty
  a_fall: assert property (p_fall) else $error("link interrupt dropped alone");
  c_event: cover property ($rose(link_change_irq_o));
  c_fault: cover property (fault_reset_o);
  c_stat: cover property (access_done_i && access_status_read_i);
endmodule // mpst_tracker_checker
bind mpst_tracker mpst_tracker_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .access_done_i(access_done_i),
  .access_status_read_i(access_status_read_i), .fault_reset_o(fault_reset_o),
  .link_change_irq_o(link_change_irq_o));
`default_nettype wire

//--- mpst_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// PHYs seen through the frame engine.
// ------------------------------------------
module mpst_phy_model (
  input wire logic clk_i, // Clock.
  input wire logic req_i, // Start an access.
  input wire logic [4:0] addr_i, // PHY address.
  input wire logic stat_i, // Generic status read.
  input wire logic [31:0] here_i, // PHYs that answer.
  input wire logic [31:0] up_i, // PHYs with link.
  input wire logic drv_en_i, // Engine drives the pin.
  input wire logic drv_val_i, // Level driven.
  input wire logic bad_i, // Corrupt the read-back.
  output logic done_o, // Access ended.
  output logic [4:0] addr_o, // Its address.
  output logic ack_o, // Acknowledge.
  output logic stat_o, // Status read.
  output logic up_o, // Link bit.
  output logic pin_o // Data pin level.
);
  logic [3:0] cnt;
  logic [4:0] la;
  logic ls;
  // Start quiet.
  initial {cnt, done_o, addr_o, ack_o, stat_o, up_o} = 0;
  // Answers 2 to 9 cycles after a request; fields garble between answers.
  always @(posedge clk_i) begin
    {done_o, addr_o, ack_o, stat_o, up_o} <= {1'b0, ~addr_o, ~ack_o, ~stat_o, ~up_o};
    if (req_i) begin
      {la, ls} <= {addr_i, stat_i};
      cnt <= 4'h2 + {1'b0, addr_i[2:0]};
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
    if (cnt == 4'h1) begin
      {done_o, addr_o, ack_o, stat_o} <= {1'b1, la, here_i[la], ls};
      up_o <= here_i[la] ? up_i[la] : 1'b1; // A silent PHY reads as all ones.
    end
  end
  // A released data line floats high through its pull-up.
  assign pin_o = drv_en_i ? drv_val_i ^ bad_i : 1'b1;
endmodule // mpst_phy_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Bench of the PHY status tracker.
// ------------------------------------------
module tb
  import mpst_pkg::*;
;
  logic clk_i = 0, reset_i = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, mdc = 0, mrun = 0;
  logic den = 0, dval = 0, req = 0, st = 0, bad = 0, awr, wrr, bv, arr, rv, dn, ack, dst, lu, pin, flt, lirq, irq;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdd, here = 0, up = 0, e_ack = 0, e_lnk = 0;
  logic [4:0] pa = 0, dad, s0 = 5'h03, s1 = 5'h1c;
  logic [1:0] brs, rrs, e_raw = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int failures = 0, n_compared = 0, seed = 90718, i;
  // Block clock, and a 200 ns link clock that runs only inside frames.
  initial forever #12.5 clk_i = ~clk_i;
  initial forever #100 if (mrun) mdc = ~mdc;
  mpst_tracker uut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrr),
    .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .mdclk_i(mdc), .mdio_data_i(pin), .mdio_drive_en_i(den), .mdio_drive_value_i(dval), .access_done_i(dn),
    .access_phy_addr_i(dad), .access_ack_i(ack), .access_status_read_i(dst), .access_link_up_i(lu),
    .fault_reset_o(flt), .link_change_irq_o(lirq), .irq_o(irq));
  mpst_phy_model phy (.clk_i(clk_i), .req_i(req), .addr_i(pa), .stat_i(st), .here_i(here), .up_i(up),
    .drv_en_i(den), .drv_val_i(dval), .bad_i(bad), .done_o(dn), .addr_o(dad), .ack_o(ack), .stat_o(dst),
    .up_o(lu), .pin_o(pin));
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // A wait that ran out ends the run.
  task automatic bound(input int n);
    if (n >= 60) begin
      failures++;
      summarize();
    end
  endtask
  // Bus master tasks; the answer is noted for the monitor.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = MPST_RESP_OKAY);
    int n;
    @(posedge clk_i);
    bq.push_back(r);
    {awa, wd, awv, wv, bry} <= {a, d, 3'h7};
    for (n = 0; n < 60; n++) begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    bound(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = MPST_RESP_OKAY);
    int n;
    @(posedge clk_i);
    rq.push_back({r, d});
    {ara, arv, rry} <= {a, 2'h3};
    for (n = 0; n < 60; n++) begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rry <= 1'b0;
    bound(n);
  endtask
  // One PHY access through the model, and the flags it must leave behind.
  task automatic acc(input logic [4:0] a, input logic s);
    int n;
    logic nl;
    @(posedge clk_i);
    {pa, st, req} <= {a, s, 1'b1};
    @(posedge clk_i);
    req <= 1'b0;
    for (n = 0; n < 60 && !dn; n++)
      @(posedge clk_i);
    bound(n);
    nl = here[a] & up[a];
    e_ack[a] = here[a];
    if (s && s0 == a && nl != e_lnk[a]) e_raw[0] = 1'b1;
    if (s && s1 == a && nl != e_lnk[a]) e_raw[1] = 1'b1;
    if (s) e_lnk[a] = nl;
  endtask
  // Matches each bus answer with the oldest note.
  always @(posedge clk_i) begin
    if (rv && rry)
      chk("read data", rq.pop_front(), {rrs, rdd});
    if (bv && bry)
      chk("write resp", 34'(bq.pop_front()), 34'(brs));
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    for (i = 0; i < 5; i++) rd(8'h04 + 8'(i * 4), 0);
    rd(8'h2c, 0, MPST_RESP_SLVERR);
    wr(8'h2c, 32'hffffffff, MPST_RESP_SLVERR);
    $display("test reset done");
    wr(MPST_SEL_FIRST_OFS, {24'h0, 3'h4, s0});
    wr(MPST_SEL_SECOND_OFS, {27'h0, s1});
    wr(MPST_INT_ENABLE_OFS, 32'h7);
    for (i = 0; i < 36; i++) begin
      here = $random(seed);
      up = $random(seed);
      acc(i % 3 == 0 ? s0 : (i % 3 == 1 ? s1 : 5'($random(seed))), i % 4 != 3);
      rd(MPST_ACK_OFS, e_ack);
      rd(MPST_LINK_OFS, e_lnk);
      rd(MPST_MASKED_OFS, {30'h0, e_raw & 2'h1});
      rd(MPST_RAW_OFS, {30'h0, e_raw});
      chk("link irq", 34'(e_raw[0]), 34'(lirq));
      chk("irq", 34'(|e_raw), 34'(irq));
      wr(MPST_RAW_OFS, {30'h0, e_raw});
      e_raw = 2'h0;
    end
    $display("test tracking done");
    wr(MPST_ACK_OFS, here);
    e_ack &= ~here;
    rd(MPST_ACK_OFS, e_ack);
    wr(MPST_LINK_OFS, 32'hffffffff);
    rd(MPST_LINK_OFS, e_lnk);
    here = '1;
    up = ~e_lnk;
    acc(s0, 1'b1);
    acc(s1, 1'b1);
    wr(MPST_RAW_OFS, 0);
    rd(MPST_RAW_OFS, 3);
    wr(MPST_MASKED_OFS, 1);
    rd(MPST_RAW_OFS, 2);
    chk("link irq", 0, 34'(lirq));
    wr(MPST_SEL_SECOND_OFS, {24'h0, 3'h4, s1});
    rd(MPST_MASKED_OFS, 2);
    chk("link irq", 1, 34'(lirq));
    wr(MPST_RAW_OFS, 2);
    rd(MPST_RAW_OFS, 0);
    chk("link irq", 0, 34'(lirq));
    $display("test clears done");
    wr(MPST_CONTROL_OFS, 32'h00040000);
    {den, dval, bad, mrun} <= 4'hf;
    for (i = 0; i < 60 && !flt; i++)
      @(posedge clk_i);
    {den, bad, mrun} <= 3'h0;
    bound(i);
    rd(MPST_CONTROL_OFS, 32'h000c0000);
    rd(MPST_INT_STATUS_OFS, 32'h4);
    chk("irq", 1, 34'(irq));
    wr(MPST_INT_CLEAR_OFS, 32'h4);
    rd(MPST_CONTROL_OFS, 32'h00040000);
    chk("irq", 0, 34'(irq));
    $display("test fault done");
    summarize();
  end
endmodule // tb
`default_nettype wire
